// >>> verilog/crt_pkg.sv
// Constants shared by the fixed-memory read timing design
package crt_pkg;
  // ----------------------------------------------------------------
  // Address register field positions (bit n of the register at n-1)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned ADDR_HIGH_A   = 10;  // Bit eleven
  localparam int unsigned ADDR_HIGH_B   = 11;  // Bit twelve
  localparam int unsigned INH_BITS      = 7;   // Low-order inhibit bits
  localparam int unsigned ADDR_BIT_EIGHT = 7;
  localparam int unsigned ADDR_BIT_NINE  = 8;
  // ----------------------------------------------------------------
  // Organisation
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned MODULES        = 6;
  localparam int unsigned STRANDS_PER_MOD = 12;
  localparam int unsigned STRANDS_TOTAL  = 72;
  localparam int unsigned STRAND_IDX_W   = 7;
  localparam int unsigned RESET_LINES    = 4;
  localparam int unsigned CORES_PER_MOD  = 512;
  localparam int unsigned WORDS_TOTAL    = 36864;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned MEM_CYCLE_NS   = 11970;  // 11.97 us
  localparam int unsigned MEM_CYCLE_CLKS = MEM_CYCLE_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_CNT_W      = 8;
  // Reset value of every timing flop and output
  localparam logic        FLOP_RESET     = 1'b0;
endpackage : crt_pkg

// >>> verilog/crt_timing_if.sv
// Timing enables passed from the cycle timing to the selectors
`timescale 1ns/1ns
interface crt_timing_if;
  logic fixed_access_flag;
  logic inhibit_envelope;
  logic set_enable;
  logic reset_enable;
  logic clear_rope_pulse;

  modport gen (
    output fixed_access_flag,
    output inhibit_envelope,
    output set_enable,
    output reset_enable,
    output clear_rope_pulse
  );
  modport use_side (
    input fixed_access_flag,
    input inhibit_envelope,
    input set_enable,
    input reset_enable,
    input clear_rope_pulse
  );
endinterface : crt_timing_if

// >>> verilog/crt_cycle_timing.sv
// Fixed-memory cycle timing flip-flops
`timescale 1ns/1ns
module crt_cycle_timing (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             fixed_access_i,
  input  wire logic             phase_three_i,
  input  wire logic             timing_pulse_one_i,
  input  wire logic             timing_pulse_two_i,
  input  wire logic             timing_pulse_three_i,
  input  wire logic             timing_pulse_six_i,
  input  wire logic             timing_pulse_eight_i,
  input  wire logic             timing_pulse_ten_i,
  input  wire logic             erasable_timing_reset_i,
  input  wire logic             global_restart_i,
  crt_timing_if.gen             tim
);
  logic inhibit_envelope_r, inhibit_envelope_nxt;
  logic sete_r, sete_nxt;
  logic rste_r, rste_nxt;
  logic pre_r, pre_nxt;
  logic clr_r, clr_nxt;
  logic t01p3;
  logic kill_ab;
  logic kill_all;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Synchronous set/reset flops decoded from pulse and phase
  always_comb begin
    t01p3    = timing_pulse_one_i & phase_three_i;
    kill_ab  = reset_i | global_restart_i | erasable_timing_reset_i;
    kill_all = reset_i | global_restart_i;
    inhibit_envelope_nxt = inhibit_envelope_r;
    sete_nxt = sete_r;
    rste_nxt = rste_r;
    pre_nxt  = pre_r;
    clr_nxt  = clr_r;
    if (timing_pulse_eight_i & phase_three_i & fixed_access_i) begin
      inhibit_envelope_nxt = 1'b1;
    end
    if (t01p3) begin
      inhibit_envelope_nxt = 1'b0;
    end
    if (timing_pulse_ten_i & phase_three_i & fixed_access_i) begin
      sete_nxt = 1'b1;
    end
    if (t01p3) begin
      sete_nxt = 1'b0;
    end
    if (t01p3 & fixed_access_i) begin
      rste_nxt = 1'b1;
    end
    if (timing_pulse_eight_i) begin
      rste_nxt = 1'b0;
    end
    if (timing_pulse_ten_i & ~fixed_access_i) begin
      pre_nxt = 1'b1;
    end
    if (timing_pulse_three_i) begin
      pre_nxt = 1'b0;
    end
    if (timing_pulse_two_i & ~fixed_access_i & pre_r) begin
      clr_nxt = 1'b1;
    end
    if (timing_pulse_six_i) begin
      clr_nxt = 1'b0;
    end
    if (kill_ab) begin
      inhibit_envelope_nxt = crt_pkg::FLOP_RESET;
      sete_nxt = crt_pkg::FLOP_RESET;
    end
    if (kill_all) begin
      rste_nxt = crt_pkg::FLOP_RESET;
      pre_nxt  = crt_pkg::FLOP_RESET;
      clr_nxt  = crt_pkg::FLOP_RESET;
    end
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    inhibit_envelope_r <= inhibit_envelope_nxt;
    sete_r <= sete_nxt;
    rste_r <= rste_nxt;
    pre_r  <= pre_nxt;
    clr_r  <= clr_nxt;
  end

  // Clear-rope falls with the first flop at pulse three
  assign tim.fixed_access_flag = fixed_access_i;
  assign tim.inhibit_envelope  = inhibit_envelope_r;
  assign tim.set_enable        = sete_r;
  assign tim.reset_enable      = rste_r;
  assign tim.clear_rope_pulse  = clr_r & pre_r;
endmodule : crt_cycle_timing

// >>> verilog/crt_inhibit_gates.sv
// Inhibit and parity-inhibit line gating
`timescale 1ns/1ns
module crt_inhibit_gates (
  input  wire logic [crt_pkg::INH_BITS-1:0] addr_low_i,
  input  wire logic                         x_parity_select_i,
  input  wire logic                         y_bottom_select_i,
  input  wire logic                         x_top_select_i,
  crt_timing_if.use_side                    tim,
  output logic      [crt_pkg::INH_BITS-1:0] inh_true_o,
  output logic      [crt_pkg::INH_BITS-1:0] inh_cmp_o,
  output logic                              parity_true_o,
  output logic                              parity_cmp_o
);
  logic par;

  // Each address bit and its complement drive one line pair
  genvar g;
  generate
    for (g = 0; g < crt_pkg::INH_BITS; g++) begin : g_inh
      assign inh_true_o[g] = tim.inhibit_envelope & ~addr_low_i[g];
      assign inh_cmp_o[g]  = tim.inhibit_envelope & addr_low_i[g];
    end
  endgenerate

  // Parity pair makes every unselected core see two inhibits
  assign par           = x_parity_select_i ^ y_bottom_select_i ^ x_top_select_i;
  assign parity_true_o = tim.inhibit_envelope & par;
  assign parity_cmp_o  = tim.inhibit_envelope & ~par;
endmodule : crt_inhibit_gates

// >>> verilog/crt_rope_read.sv
// Top of the fixed-memory read timing and selection logic
`timescale 1ns/1ns
// What this block does
// - Bit eleven or twelve of the address marks a fixed access.
// - All fixed timing lies in one 11.97 us memory cycle.
// - Timing signals except clear-rope need the fixed-access flag.
// - Inhibit envelope sets at pulse eight phase three, clears at one.
// - Inhibit envelope enables current in the selected inhibit lines.
// - Set enable sets at pulse ten phase three, clears at one.
// - Reset enable runs from pulse one phase three to pulse eight.
// - Clear-rope sequence: pre-flop at ten, set two, fall three, clear six.
// - Clear-rope appears only when fixed memory is not addressed.
// - Erasable timing reset clears inhibit envelope and set enable.
// - Global restart clears all other timing flops.
// - Seven low address bits and complements drive fourteen inhibit lines.
// - Parity inhibit pair comes from three selection signals.
// - Bit nine picks one of two set lines, bits eight and nine one of four reset lines.
// - Exactly one set line at set time, two planes each.
// - Exactly one reset line at reset time, one plane each.
// - One of six modules and one of twelve strands pick a strand.
// - Unselected cores are inhibited by at least two lines.
// - Sense amplifiers enabled during reset time read one word.
// - Fixed store is 36,864 words, 512 cores per module.
// - Clear-rope stops fixed data reaching the shared lines.
// - Strobe request becomes the sense strobe loading the buffer.
module crt_rope_read (
  input  wire logic                               clk_i,
  input  wire logic                               reset_i,
  input  wire logic [crt_pkg::ADDR_W-1:0]         address_i,
  input  wire logic [crt_pkg::STRAND_IDX_W-1:0]   strand_index_i,
  input  wire logic                               phase_three_i,
  input  wire logic                               phase_four_i,
  input  wire logic                               timing_pulse_one_i,
  input  wire logic                               timing_pulse_two_i,
  input  wire logic                               timing_pulse_three_i,
  input  wire logic                               timing_pulse_six_i,
  input  wire logic                               timing_pulse_eight_i,
  input  wire logic                               timing_pulse_ten_i,
  input  wire logic                               erasable_timing_reset_i,
  input  wire logic                               global_restart_i,
  input  wire logic                               erasable_strobe_request_i,
  input  wire logic                               x_parity_select_i,
  input  wire logic                               y_bottom_select_i,
  input  wire logic                               x_top_select_i,
  input  wire logic [crt_pkg::WORD_W-1:0]         sense_data_i,
  output logic                                    fixed_access_flag_o,
  output logic                                    inhibit_envelope_o,
  output logic                                    set_enable_o,
  output logic                                    reset_enable_o,
  output logic                                    clear_rope_pulse_o,
  output logic [crt_pkg::INH_BITS-1:0]            inhibit_line_o,
  output logic [crt_pkg::INH_BITS-1:0]            inhibit_line_cmp_o,
  output logic                                    parity_inhibit_o,
  output logic                                    parity_inhibit_cmp_o,
  output logic                                    set_line_low_pair_o,
  output logic                                    set_line_high_pair_o,
  output logic                                    reset_line_plane_a_o,
  output logic                                    reset_line_plane_b_o,
  output logic                                    reset_line_plane_c_o,
  output logic                                    reset_line_plane_d_o,
  output logic [crt_pkg::MODULES-1:0]             module_select_o,
  output logic [crt_pkg::STRANDS_PER_MOD-1:0]     strand_select_o,
  output logic                                    sense_enable_o,
  output logic                                    sense_strobe_o,
  output logic                                    buffer_load_o,
  output logic [crt_pkg::WORD_W-1:0]              buffer_word_o,
  output logic                                    cycle_overrun_o
);
  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Two-bit one-hot decode, used for reset lines and strand groups
  function automatic logic [3:0] dec4(input logic [1:0] sel);
    logic [3:0] v;
    v = 4'h0;
    v[sel] = 1'b1;
    return v;
  endfunction : dec4

  // Two-bit code of a value below four, taken from a wider index
  function automatic logic [1:0] low2(input logic [6:0] v);
    return v[1:0];
  endfunction : low2

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  crt_timing_if tim ();

  logic                                fixed_access;
  logic [crt_pkg::INH_BITS-1:0]        inh_true;
  logic [crt_pkg::INH_BITS-1:0]        inh_cmp;
  logic                                par_true;
  logic                                par_cmp;
  logic [3:0]                          rst_dec;
  logic [6:0]                          mod_idx;
  logic [6:0]                          str_idx;
  logic [crt_pkg::MODULES-1:0]         mod_dec;
  logic [crt_pkg::STRANDS_PER_MOD-1:0] str_dec;
  logic                                strand_valid;

  logic                                flag_r, flag_nxt;
  logic                                inhibit_envelope_r, inhibit_envelope_nxt;
  logic                                sete_r, sete_nxt;
  logic                                rste_r, rste_nxt;
  logic                                clr_r, clr_nxt;
  logic [crt_pkg::INH_BITS-1:0]        inh_r, inh_nxt;
  logic [crt_pkg::INH_BITS-1:0]        inhc_r, inhc_nxt;
  logic                                par_r, par_nxt;
  logic                                parc_r, parc_nxt;
  logic [1:0]                          setl_r, setl_nxt;
  logic [3:0]                          rstl_r, rstl_nxt;
  logic [crt_pkg::MODULES-1:0]         mod_r, mod_nxt;
  logic [crt_pkg::STRANDS_PER_MOD-1:0] str_r, str_nxt;
  logic                                sen_r, sen_nxt;
  logic                                stb_r, stb_nxt;
  logic                                ld_r, ld_nxt;
  logic [crt_pkg::WORD_W-1:0]          word_r, word_nxt;
  logic [crt_pkg::CYC_CNT_W-1:0]       cyc_r, cyc_nxt;
  logic                                ovr_r, ovr_nxt;

  // ----------------------------------------------------------------
  // Fixed-access detection
  // ----------------------------------------------------------------
  // Either high address bit selects the ropes
  assign fixed_access = address_i[crt_pkg::ADDR_HIGH_A]
                      | address_i[crt_pkg::ADDR_HIGH_B];

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  crt_cycle_timing u_timing (
    .clk_i                   (clk_i),
    .reset_i                 (reset_i),
    .fixed_access_i          (fixed_access),
    .phase_three_i           (phase_three_i),
    .timing_pulse_one_i      (timing_pulse_one_i),
    .timing_pulse_two_i      (timing_pulse_two_i),
    .timing_pulse_three_i    (timing_pulse_three_i),
    .timing_pulse_six_i      (timing_pulse_six_i),
    .timing_pulse_eight_i    (timing_pulse_eight_i),
    .timing_pulse_ten_i      (timing_pulse_ten_i),
    .erasable_timing_reset_i (erasable_timing_reset_i),
    .global_restart_i        (global_restart_i),
    .tim                     (tim.gen)
  );

  crt_inhibit_gates u_inhibit (
    .addr_low_i        (address_i[crt_pkg::INH_BITS-1:0]),
    .x_parity_select_i (x_parity_select_i),
    .y_bottom_select_i (y_bottom_select_i),
    .x_top_select_i    (x_top_select_i),
    .tim               (tim.use_side),
    .inh_true_o        (inh_true),
    .inh_cmp_o         (inh_cmp),
    .parity_true_o     (par_true),
    .parity_cmp_o      (par_cmp)
  );

  // ----------------------------------------------------------------
  // Set, reset, module and strand selection
  // ----------------------------------------------------------------
  // Bits eight and nine choose one reset plane
  assign rst_dec = dec4({address_i[crt_pkg::ADDR_BIT_NINE],
                         address_i[crt_pkg::ADDR_BIT_EIGHT]});

  // Strand index splits into module (six) and strand (twelve)
  assign strand_valid = strand_index_i < 7'(crt_pkg::STRANDS_TOTAL);
  assign mod_idx = strand_index_i / 7'(crt_pkg::STRANDS_PER_MOD);
  assign str_idx = strand_index_i % 7'(crt_pkg::STRANDS_PER_MOD);

  // Module is one of six, strand a 3-by-4 combination of twelve
  always_comb begin
    mod_dec = '0;
    str_dec = '0;
    if (strand_valid) begin
      mod_dec[mod_idx[2:0]] = 1'b1;
      str_dec = {dec4(low2(str_idx >> 2)) == 4'h4 ? dec4(low2(str_idx)) : 4'h0,
                 dec4(low2(str_idx >> 2)) == 4'h2 ? dec4(low2(str_idx)) : 4'h0,
                 dec4(low2(str_idx >> 2)) == 4'h1 ? dec4(low2(str_idx)) : 4'h0};
    end
  end

  // ----------------------------------------------------------------
  // Output stage next values
  // ----------------------------------------------------------------
  // Every port is registered; selection follows the enables
  always_comb begin
    flag_nxt = fixed_access;
    inhibit_envelope_nxt = tim.inhibit_envelope;
    sete_nxt = tim.set_enable;
    rste_nxt = tim.reset_enable;
    clr_nxt  = tim.clear_rope_pulse;
    inh_nxt  = inh_true;
    inhc_nxt = inh_cmp;
    par_nxt  = par_true;
    parc_nxt = par_cmp;
    // One set line covers a pair of planes
    setl_nxt = {tim.set_enable & address_i[crt_pkg::ADDR_BIT_NINE],
                tim.set_enable & ~address_i[crt_pkg::ADDR_BIT_NINE]};
    // One reset line covers a single plane
    rstl_nxt = tim.reset_enable ? rst_dec : 4'h0;
    mod_nxt  = tim.reset_enable ? mod_dec : '0;
    str_nxt  = tim.reset_enable ? str_dec : '0;
    sen_nxt  = tim.reset_enable & tim.fixed_access_flag;
    stb_nxt  = erasable_strobe_request_i;
    ld_nxt   = 1'b0;
    word_nxt = word_r;
    // Strobe moves the sensed word into the buffer
    if (erasable_strobe_request_i & tim.reset_enable) begin
      ld_nxt   = 1'b1;
      word_nxt = sense_data_i;
    end
    // Clear-rope keeps fixed data off the shared lines
    if (tim.clear_rope_pulse) begin
      ld_nxt   = 1'b0;
      word_nxt = '0;
    end
    // Cycle length watch, restarted at pulse one phase three
    cyc_nxt = cyc_r;
    ovr_nxt = ovr_r;
    if (timing_pulse_one_i & phase_three_i) begin
      cyc_nxt = '0;
      ovr_nxt = 1'b0;
    end else if (cyc_r != 8'(crt_pkg::MEM_CYCLE_CLKS)) begin
      cyc_nxt = cyc_r + 8'h01;
    end else begin
      ovr_nxt = 1'b1;
    end
    if (reset_i | global_restart_i) begin
      inhibit_envelope_nxt = crt_pkg::FLOP_RESET;
      sete_nxt = crt_pkg::FLOP_RESET;
      rste_nxt = crt_pkg::FLOP_RESET;
      clr_nxt  = crt_pkg::FLOP_RESET;
      inh_nxt  = '0;
      inhc_nxt = '0;
      par_nxt  = 1'b0;
      parc_nxt = 1'b0;
      setl_nxt = 2'h0;
      rstl_nxt = 4'h0;
      mod_nxt  = '0;
      str_nxt  = '0;
      sen_nxt  = 1'b0;
      ld_nxt   = 1'b0;
      cyc_nxt  = '0;
      ovr_nxt  = 1'b0;
    end
    if (reset_i) begin
      flag_nxt = 1'b0;
      stb_nxt  = 1'b0;
      word_nxt = '0;
    end
  end

  // Output register stage
  always_ff @(posedge clk_i) begin
    flag_r <= flag_nxt;
    inhibit_envelope_r <= inhibit_envelope_nxt;
    sete_r <= sete_nxt;
    rste_r <= rste_nxt;
    clr_r  <= clr_nxt;
    inh_r  <= inh_nxt;
    inhc_r <= inhc_nxt;
    par_r  <= par_nxt;
    parc_r <= parc_nxt;
    setl_r <= setl_nxt;
    rstl_r <= rstl_nxt;
    mod_r  <= mod_nxt;
    str_r  <= str_nxt;
    sen_r  <= sen_nxt;
    stb_r  <= stb_nxt;
    ld_r   <= ld_nxt;
    word_r <= word_nxt;
    cyc_r  <= cyc_nxt;
    ovr_r  <= ovr_nxt;
  end

  // ----------------------------------------------------------------
  // Port drive
  // ----------------------------------------------------------------
  assign fixed_access_flag_o  = flag_r;
  assign inhibit_envelope_o   = inhibit_envelope_r;
  assign set_enable_o         = sete_r;
  assign reset_enable_o       = rste_r;
  assign clear_rope_pulse_o   = clr_r;
  assign inhibit_line_o       = inh_r;
  assign inhibit_line_cmp_o   = inhc_r;
  assign parity_inhibit_o     = par_r;
  assign parity_inhibit_cmp_o = parc_r;
  assign set_line_low_pair_o  = setl_r[0];
  assign set_line_high_pair_o = setl_r[1];
  assign reset_line_plane_a_o = rstl_r[0];
  assign reset_line_plane_b_o = rstl_r[1];
  assign reset_line_plane_c_o = rstl_r[2];
  assign reset_line_plane_d_o = rstl_r[3];
  assign module_select_o      = mod_r;
  assign strand_select_o      = str_r;
  assign sense_enable_o       = sen_r;
  assign sense_strobe_o       = stb_r;
  assign buffer_load_o        = ld_r;
  assign buffer_word_o        = word_r;
  assign cycle_overrun_o      = ovr_r;
endmodule : crt_rope_read

// >>> verification/crt_cpu_model.sv
// Processor-side timing pulse source for the fixed-memory bench
`timescale 1ns/1ns
module crt_cpu_model (
  input  wire logic [3:0] tp_i,
  output logic      [5:0] tp_o
);
  // Pulse number to one-hot pulse lines; never two pulses at once
  assign tp_o = {tp_i == 4'hA, tp_i == 4'h8, tp_i == 4'h6,
                 tp_i == 4'h3, tp_i == 4'h2, tp_i == 4'h1};
endmodule : crt_cpu_model

// >>> verification/crt_rope_read_checker.sv
// Port assertions for the fixed-memory read timing block
`timescale 1ns/1ns
module crt_rope_read_checker (
  input wire logic                        clk_i,
  input wire logic                        reset_i,
  input wire logic [crt_pkg::ADDR_W-1:0]  address_i,
  input wire logic                        phase_three_i,
  input wire logic                        timing_pulse_one_i,
  input wire logic                        timing_pulse_three_i,
  input wire logic                        timing_pulse_eight_i,
  input wire logic                        timing_pulse_ten_i,
  input wire logic                        erasable_timing_reset_i,
  input wire logic                        global_restart_i,
  input wire logic                        fixed_access_flag_o,
  input wire logic                        inhibit_envelope_o,
  input wire logic                        set_enable_o,
  input wire logic                        reset_enable_o,
  input wire logic                        clear_rope_pulse_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Set conditions only count with a fixed access and no clear
  logic ok;
  assign ok = fixed_access_flag_o && !erasable_timing_reset_i && !global_restart_i;
  property p_fix; !$past(reset_i) && !$past(global_restart_i) |->
    fixed_access_flag_o == $past(address_i[10] || address_i[11]); endproperty
  a_fix: assert property (p_fix) else $error("fixed flag wrong");
  property p_env; timing_pulse_eight_i && phase_three_i && ok |-> ##2 inhibit_envelope_o;
  endproperty
  a_env: assert property (p_env) else $error("envelope not set");
  property p_one; timing_pulse_one_i && phase_three_i |-> ##2 !inhibit_envelope_o && !set_enable_o;
  endproperty
  a_one: assert property (p_one) else $error("envelope or set enable held");
  property p_set; timing_pulse_ten_i && phase_three_i && ok |-> ##2 set_enable_o; endproperty
  a_set: assert property (p_set) else $error("set enable not set");
  property p_rst; timing_pulse_one_i && phase_three_i && ok |-> ##2 reset_enable_o; endproperty
  a_rst: assert property (p_rst) else $error("reset enable not set");
  property p_tmr; erasable_timing_reset_i |-> ##2 !inhibit_envelope_o && !set_enable_o;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timing reset ignored");
  property p_gr; global_restart_i |-> ##2 !reset_enable_o && !clear_rope_pulse_o; endproperty
  a_gr: assert property (p_gr) else $error("restart ignored");
  property p_clr; timing_pulse_three_i |-> ##2 !clear_rope_pulse_o; endproperty
  a_clr: assert property (p_clr) else $error("clear pulse held");
endmodule : crt_rope_read_checker
bind crt_rope_read crt_rope_read_checker chk_u (.*);

// >>> verification/tb_crt_rope_read.sv
// Self-checking bench for the fixed-memory read timing block
`timescale 1ns/1ns
module tb_crt_rope_read;
  logic clk_i = 0, reset_i = 1, ph3 = 0, fx, env, sen, ren, clr, p, pc, slo, shi, sne, stb, ld, ovr;
  wire [3:0] rl;
  logic [15:0] addr = 0, sd = 16'hBEEF, bw;
  logic [6:0] sidx = 7'h0E, il, ilc;
  logic [3:0] tp = 0;
  logic [2:0] c = 0, ps = 3'h4;
  logic [5:0] tpl, ms;
  logic [11:0] ss;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  crt_cpu_model cpu_u (.tp_i(tp), .tp_o(tpl));
  crt_rope_read dut_u (.clk_i(clk_i), .reset_i(reset_i), .address_i(addr),
    .strand_index_i(sidx), .phase_three_i(ph3), .phase_four_i(1'b0),
    .timing_pulse_one_i(tpl[0]), .timing_pulse_two_i(tpl[1]), .timing_pulse_three_i(tpl[2]),
    .timing_pulse_six_i(tpl[3]), .timing_pulse_eight_i(tpl[4]), .timing_pulse_ten_i(tpl[5]),
    .erasable_timing_reset_i(c[1]), .global_restart_i(c[2]), .erasable_strobe_request_i(c[0]),
    .x_parity_select_i(ps[2]), .y_bottom_select_i(ps[1]), .x_top_select_i(ps[0]),
    .sense_data_i(sd), .fixed_access_flag_o(fx), .inhibit_envelope_o(env),
    .set_enable_o(sen), .reset_enable_o(ren), .clear_rope_pulse_o(clr), .inhibit_line_o(il),
    .inhibit_line_cmp_o(ilc), .parity_inhibit_o(p), .parity_inhibit_cmp_o(pc),
    .set_line_low_pair_o(slo), .set_line_high_pair_o(shi), .reset_line_plane_a_o(rl[0]),
    .reset_line_plane_b_o(rl[1]), .reset_line_plane_c_o(rl[2]), .reset_line_plane_d_o(rl[3]),
    .module_select_o(ms), .strand_select_o(ss), .sense_enable_o(sne), .sense_strobe_o(stb),
    .buffer_load_o(ld), .buffer_word_o(bw), .cycle_overrun_o(ovr));
  // Clock and hang guard
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One pulse cycle with optional controls, then let the outputs settle
  task automatic step(input logic [3:0] n, input logic ph, input logic [2:0] k);
    @(negedge clk_i);
    tp = n;
    ph3 = ph;
    c = k;
    @(negedge clk_i);
    tp = 4'h0;
    ph3 = 1'b0;
    c = 3'h0;
    repeat (3) @(negedge clk_i);
  endtask : step
  task automatic t_fixed;
    addr = 16'h0D35;
    step(4'h8, 1, 0);
    chk("fixed", 16'h1, 16'(fx));
    chk("inhibit", {7'h4A, 7'h35, 2'b10}, {il, ilc, p, pc});
    step(4'hA, 1, 0);
    chk("set", 16'h5, 16'({sen, slo, shi}));
    step(4'h1, 1, 0);
    chk("reset", 16'h29, 16'({env, sen, ren, rl, sne}));
    chk("module", 16'h2, 16'(ms));
    chk("strand", 16'h4, 16'(ss));
    @(negedge clk_i);
    c = 3'h1;
    @(negedge clk_i);
    c = 3'h0;
    chk("strobe", 16'h3, 16'({stb, ld}));
    chk("buffer", 16'hBEEF, bw);
    @(negedge clk_i);
    chk("load end", 16'h0, 16'(ld));
    step(4'hA, 0, 0);
    step(4'h2, 0, 0);
    chk("no clear", 16'h0, 16'(clr));
    step(4'h8, 0, 0);
    chk("reset end", 16'h0, 16'({ren, rl}));
  endtask : t_fixed
  task automatic t_clear;
    addr = 16'h0000;
    step(4'hA, 1, 0);
    step(4'h2, 0, 0);
    step(4'h8, 1, 0);
    chk("clear", 16'h4, 16'({clr, env, sen}));
    chk("cleared word", 16'h0, bw);
    step(4'h3, 0, 0);
    chk("clear end", 16'h0, 16'(clr));
    step(4'h6, 0, 0);
  endtask : t_clear
  task automatic t_resets;
    addr = 16'h0400;
    step(4'h8, 1, 0);
    step(4'hA, 1, 0);
    step(4'h0, 0, 3'h2);
    chk("timing reset", 16'h0, 16'({env, sen}));
    step(4'h1, 1, 0);
    step(4'h0, 0, 3'h4);
    chk("restart", 16'h1, 16'({ren, fx}));
  endtask : t_resets
  // Long gap without pulse one raises the overrun flag, pulse one clears it
  task automatic t_overrun;
    chk("no overrun", 16'h0, 16'(ovr));
    repeat (245) @(negedge clk_i);
    chk("overrun", 16'h1, 16'(ovr));
    step(4'h1, 1, 0);
    chk("overrun cleared", 16'h0, 16'(ovr));
  endtask : t_overrun
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (8) @(negedge clk_i);
    reset_i = 1'b0;
    t_fixed();
    t_clear();
    t_resets();
    t_overrun();
    conclude();
  end
endmodule : tb_crt_rope_read
